/* File: hdl/psf_cycle.sv */
/*
  Per-process cycle counter: wrapping count plus per-process bias.
  Assumes writes arrive from the state file on the same clock.
*/
`timescale 1ns/1ps
module psf_cycle (
  input  wire logic clk_i,
  input  wire logic rst_i,
  psf_cyc_if.cyc    port_c
);
  import psf_pkg::*;

  // Low half counts every clock unless written that cycle, and wraps freely
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c.cnt <= 32'h0;
    end else if (port_c.wr_cnt) begin
      port_c.cnt <= port_c.wdata;
    end else begin
      port_c.cnt <= port_c.cnt + 32'h1; // RULE_11
    end
  end

  // High half is the bias set by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c.bias <= 32'h0;
    end else if (port_c.wr_bias) begin
      port_c.bias <= port_c.wdata; // RULE_11
    end
  end

  // Carry out is dropped, so the total wraps
  assign port_c.total = port_c.bias + port_c.cnt; // RULE_12
endmodule // psf_cycle

/* File: hdl/psf_state_file.sv */
/*
  Privileged CPU state file: vectors, stack saves, status word, PC,
  page roots, reservation and value registers, on a Wishbone slave.
  Assumes core event inputs are on clk_i and pulse for one cycle.
*/
`timescale 1ns/1ps
`include "psf_cfg.svh"
module psf_state_file #(
  parameter logic [63:0] CPU_ID    = 64'h0,
  parameter int          CPU_LIMIT = 1
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              exc_i,
  input  wire psf_pkg::psf_exc_e exc_kind_i,
  input  wire psf_pkg::psf_word_t cur_sp_i,
  input  wire logic              ret_i,
  input  wire logic [3:0]        ret_ps_i,
  input  wire logic              ll_i,
  input  wire logic              sc_i,
  input  wire logic              fp_issue_i,
  input  wire logic              stk_access_i,
  input  wire psf_pkg::psf_word_t stk_addr_i,
  input  wire psf_pkg::psf_word_t xlat_va_i,
  output logic                   sc_ok_o,
  output logic                   fp_fault_o,
  output logic                   fp_commit_o,
  output logic                   dispatch_o,
  output psf_pkg::psf_word_t     dispatch_pc_o,
  output logic                   gp_wr_o,
  output psf_pkg::psf_word_t     gp_o,
  output logic                   sp_load_o,
  output psf_pkg::psf_word_t     sp_o,
  output psf_pkg::psf_word_t     xlat_root_o,
  output logic                   stack_halt_o,
  output logic                   perf_watch_o,
  output psf_pkg::psf_word_t     pc_o,
  output logic                   user_mode_o,
  output logic [2:0]             ipl_o
);
  import psf_pkg::*;

  psf_word_t   regs [0:`PSF_NREG-1];
  logic [3:0]  ps;
  logic        fp_en;
  logic        perf_watch;
  logic        lock;
  logic        intr_seen;
  logic        halt;
  logic [2:0]  mchk_sum;
  logic [31:0] rdata;
  logic        bus_wr;
  logic        wide_hit;
  logic [4:0]  widx;
  logic [5:0]  word;
  logic        priv_ok;
  logic        fp_bad;
  logic [4:0]  vec_idx;
  psf_word_t   merged;
  psf_word_t   vec;

  psf_cyc_if cyc_link ();

  psf_cycle i_psf_cycle (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .port_c (cyc_link.cyc)
  );

  // Merge one bus word into a 32-bit field under byte enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Decode: write commits at the edge where the master sees ack
  assign word     = wb_adr_i[7:2];
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wide_hit = word < `PSF_W_WIDE_END;
  assign widx     = word[5:1];
  // Per-CPU value is closed to user mode
  assign priv_ok  = (widx != `PSF_R_PERCPU) || !ps[`PSF_MODE_BIT]; // RULE_19
  assign fp_bad   = fp_issue_i && !fp_en; // RULE_02
  assign vec_idx  = {2'h0, exc_kind_i};
  assign vec      = regs[vec_idx];

  // Byte-lane merge of the selected wide register half
  always_comb begin
    merged = regs[widx];
    if (word[0]) begin
      merged[63:32] = lane_merge(regs[widx][63:32], wb_dat_i, wb_sel_i);
    end else begin
      merged[31:0] = lane_merge(regs[widx][31:0], wb_dat_i, wb_sel_i);
    end
  end

  // Wishbone ack: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Wide registers; core events are written last so they win
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `PSF_NREG; i++) begin
        regs[i] <= 64'h0;
      end
      regs[`PSF_R_BOUND] <= `PSF_BOUND_RST; // RULE_18
    end else begin
      if (bus_wr && wide_hit && priv_ok) begin // RULE_20
        regs[widx] <= merged; // RULE_10 RULE_15 RULE_21
        if (widx == `PSF_R_PC) begin
          regs[widx][1:0] <= `PSF_PC_LOW; // RULE_09
        end
      end
      if (exc_i) begin
        regs[`PSF_R_PC] <= {vec[63:2], `PSF_PC_LOW}; // RULE_01
        if (ps[`PSF_MODE_BIT]) begin
          regs[`PSF_R_USER_SP] <= cur_sp_i; // RULE_06
        end
      end else if (fp_bad) begin
        // Only the PC moves; the faulting op leaves all else alone
        regs[`PSF_R_PC] <= {regs[`PSF_R_IFV][63:2], `PSF_PC_LOW}; // RULE_24
      end else if (ret_i && ret_ps_i[`PSF_MODE_BIT]) begin
        regs[`PSF_R_KERN_SP] <= cur_sp_i; // RULE_05
      end
    end
  end

  // Status word: exceptions enter kernel, returns reload it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps <= `PSF_PS_RST;
    end else if (exc_i) begin
      ps[`PSF_MODE_BIT] <= 1'b0; // RULE_14
    end else if (ret_i) begin
      ps <= ret_ps_i; // RULE_23
    end else if (bus_wr && word == `PSF_W_PS) begin
      ps <= wb_dat_i[3:0]; // RULE_14
    end
  end

  // Context-block word at offset 40: FP enable and monitor request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_en      <= 1'b0;
      perf_watch <= 1'b0;
    end else if (bus_wr && wb_sel_i[0] && word == `PSF_W_CTX_LO) begin
      fp_en <= wb_dat_i[`PSF_FPEN_BIT]; // RULE_02
    end else if (bus_wr && wb_sel_i[3] && word == `PSF_W_CTX_HI) begin
      perf_watch <= wb_dat_i[`PSF_WATCH_BIT]; // RULE_13
    end
  end

  // Reservation: a new load-locked beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock <= 1'b0;
    end else if (ll_i) begin
      lock <= 1'b1; // RULE_07
    end else if (sc_i || ret_i) begin
      lock <= 1'b0; // RULE_07
    end else if (bus_wr && word == `PSF_W_MISC) begin
      lock <= wb_dat_i[`PSF_LOCK_BIT];
    end
  end

  // Interrupt-seen: a new interrupt beats a return in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_seen <= 1'b0;
    end else if (exc_i && exc_kind_i == PSF_EXC_INT) begin
      intr_seen <= 1'b1;
    end else if (ret_i) begin
      intr_seen <= 1'b0; // RULE_03
    end
  end

  // Stack halt is sticky; software clears it by writing a one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt <= 1'b0;
    end else if (stk_access_i && stk_addr_i[2:0] != `PSF_STK_ALIGN) begin
      halt <= 1'b1; // RULE_16
    end else if (bus_wr && word == `PSF_W_MISC && wb_dat_i[`PSF_HALT_BIT]) begin
      halt <= 1'b0;
    end
  end

  // Machine-check summary is plain software state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mchk_sum <= `PSF_MCHK_RST;
    end else if (bus_wr && wb_sel_i[0] && word == `PSF_W_MISC) begin
      mchk_sum <= wb_dat_i[`PSF_MCHK_LSB +: 3]; // RULE_08
    end
  end

  // Exception dispatch: new PC, global pointer and stack switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dispatch_o    <= 1'b0;
      dispatch_pc_o <= 64'h0;
      gp_wr_o       <= 1'b0;
      gp_o          <= 64'h0;
      sp_load_o     <= 1'b0;
      sp_o          <= 64'h0;
    end else begin
      dispatch_o <= exc_i || fp_bad;
      gp_wr_o    <= exc_i;
      sp_load_o  <= 1'b0;
      if (exc_i) begin
        dispatch_pc_o <= {vec[63:2], `PSF_PC_LOW}; // RULE_01
        gp_o          <= regs[`PSF_R_KERN_GP]; // RULE_04
        if (ps[`PSF_MODE_BIT]) begin
          sp_load_o <= 1'b1;
          sp_o      <= regs[`PSF_R_KERN_SP]; // RULE_05
        end
      end else if (fp_bad) begin
        dispatch_pc_o <= {regs[`PSF_R_IFV][63:2], `PSF_PC_LOW};
      end else if (ret_i && ret_ps_i[`PSF_MODE_BIT]) begin
        sp_load_o <= 1'b1;
        sp_o      <= regs[`PSF_R_USER_SP]; // RULE_06
      end
    end
  end

  // Instruction outcomes and translation root, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_ok_o     <= 1'b0;
      fp_fault_o  <= 1'b0;
      fp_commit_o <= 1'b0;
      xlat_root_o <= 64'h0;
    end else begin
      sc_ok_o     <= sc_i && lock; // RULE_07
      fp_fault_o  <= fp_bad; // RULE_02
      fp_commit_o <= fp_issue_i && fp_en; // RULE_24
      if (xlat_va_i >= regs[`PSF_R_BOUND]) begin
        xlat_root_o <= regs[`PSF_R_SYS_RT]; // RULE_17
      end else begin
        xlat_root_o <= regs[`PSF_R_PROC_RT]; // RULE_15
      end
    end
  end

  // Cycle counter halves written through the link
  assign cyc_link.wdata   = wb_dat_i;
  assign cyc_link.wr_cnt  = bus_wr && word == `PSF_W_CYC_LO; // RULE_11
  assign cyc_link.wr_bias = bus_wr && word == `PSF_W_CYC_HI;

  // Read mux; unmapped words and closed registers read as zero
  always_comb begin
    rdata = 32'h0;
    if (wide_hit) begin
      if (priv_ok) begin
        rdata = word[0] ? regs[widx][63:32] : regs[widx][31:0];
      end
      if (widx == `PSF_R_PC && !word[0]) begin
        rdata[1:0] = `PSF_PC_LOW; // RULE_09
      end
    end else begin
      case (word)
        `PSF_W_CYC_LO:  rdata = cyc_link.cnt;
        `PSF_W_CYC_HI:  rdata = cyc_link.bias;
        `PSF_W_CYC_TOT: rdata = cyc_link.total; // RULE_12
        `PSF_W_PS:      rdata = {28'h0, ps};
        `PSF_W_MISC: begin
          rdata[`PSF_LOCK_BIT]      = lock;
          rdata[`PSF_SEEN_BIT]      = intr_seen;
          rdata[`PSF_HALT_BIT]      = halt;
          rdata[`PSF_MCHK_LSB +: 3] = mchk_sum;
        end
        `PSF_W_CTX_LO:  rdata[`PSF_FPEN_BIT] = fp_en;
        `PSF_W_CTX_HI:  rdata[`PSF_WATCH_BIT] = perf_watch;
        `PSF_W_CPU_LO:  rdata = CPU_ID[31:0]; // RULE_22
        `PSF_W_CPU_HI:  rdata = CPU_ID[63:32];
        default:        rdata = 32'h0;
      endcase
    end
  end

  // Read data is latched with ack so it holds while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= rdata;
    end
  end

  // Status views for the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o         <= 64'h0;
      user_mode_o  <= 1'b0;
      ipl_o        <= 3'h0;
      perf_watch_o <= 1'b0;
      stack_halt_o <= 1'b0;
    end else begin
      pc_o         <= {regs[`PSF_R_PC][63:2], `PSF_PC_LOW};
      user_mode_o  <= ps[`PSF_MODE_BIT]; // RULE_14
      ipl_o        <= ps[2:0]; // RULE_23
      perf_watch_o <= perf_watch; // RULE_13
      stack_halt_o <= halt; // RULE_16
    end
  end
endmodule // psf_state_file

/* File: include/psf_cfg.svh */
/*
  Constants of the privileged CPU state file: word addresses, field
  positions and reset values. Assumes a 32-bit bus that addresses bytes.
*/
// Behaviour
// RULE_01 - Six dispatch vectors, selected vector becomes PC
// RULE_02 - FP enable bit; FP op while clear faults
// RULE_03 - Interrupt-seen bit cleared by any return
// RULE_04 - Exception entry loads kernel global pointer to R15
// RULE_05 - Kernel stack pointer saved while in user
// RULE_06 - User stack pointer saved while in kernel
// RULE_07 - Reservation bit set by LL, tested by SC
// RULE_08 - Three-bit machine-check error summary register
// RULE_09 - PC low two bits read zero, ignore writes
// RULE_10 - Context block base address register
// RULE_11 - Cycle register: wrapping low counter, high bias
// RULE_12 - Process cycle total is bias plus count mod 2^32
// RULE_13 - Context bit 62 flags process for monitoring
// RULE_14 - Status word: bit 3 mode, bits 2:0 IPL
// RULE_15 - Page table root frame number register
// RULE_16 - Unaligned kernel stack access halts
// RULE_17 - VA at/above boundary uses system root
// RULE_18 - Boundary resets to all ones
// RULE_19 - Per-CPU value, kernel mode access only
// RULE_20 - Per-process value, any mode
// RULE_21 - Virtual page table pointer register
// RULE_22 - Read-only CPU number below CPU limit
// RULE_23 - IPL bits 2:0, mode bit 3
// RULE_24 - Disabled FP op updates no register
`ifndef PSF_CFG_SVH
`define PSF_CFG_SVH

// Slots of the wide register array
`define PSF_R_IFV      5'h01
`define PSF_R_KERN_GP  5'h06
`define PSF_R_KERN_SP  5'h07
`define PSF_R_USER_SP  5'h08
`define PSF_R_PC       5'h09
`define PSF_R_CTX_BASE 5'h0A
`define PSF_R_PROC_RT  5'h0B
`define PSF_R_SYS_RT   5'h0C
`define PSF_R_BOUND    5'h0D
`define PSF_R_VPT      5'h0E
`define PSF_R_PERCPU   5'h0F
`define PSF_R_PERPROC  5'h10
`define PSF_NREG       17

// Word addresses (byte address is four times these)
`define PSF_W_WIDE_END 6'h22
`define PSF_W_CYC_LO   6'h22
`define PSF_W_CYC_HI   6'h23
`define PSF_W_PS       6'h24
`define PSF_W_MISC     6'h25
`define PSF_W_CTX_LO   6'h26
`define PSF_W_CTX_HI   6'h27
`define PSF_W_CPU_LO   6'h28
`define PSF_W_CPU_HI   6'h29
`define PSF_W_CYC_TOT  6'h2A

// Fields
`define PSF_MODE_BIT   3
`define PSF_FPEN_BIT   0
`define PSF_WATCH_BIT  30
`define PSF_LOCK_BIT   0
`define PSF_SEEN_BIT   1
`define PSF_HALT_BIT   2
`define PSF_MCHK_LSB   4
`define PSF_PC_LOW     2'h0
`define PSF_STK_ALIGN  3'h0

// Reset values
`define PSF_PS_RST     4'h7
`define PSF_BOUND_RST  64'hFFFFFFFFFFFFFFFF
`define PSF_MCHK_RST   3'h0

`endif

/* File: include/psf_cyc_if.sv */
/*
  Link between the state file and its cycle counter.
  Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface psf_cyc_if;
  logic [31:0] wdata;
  logic        wr_cnt;
  logic        wr_bias;
  logic [31:0] cnt;
  logic [31:0] bias;
  logic [31:0] total;
  modport ctl (output wdata, wr_cnt, wr_bias, input cnt, bias, total);
  modport cyc (input wdata, wr_cnt, wr_bias, output cnt, bias, total);
endinterface

/* File: include/psf_pkg.sv */
/*
  Types of the privileged CPU state file. Assumes psf_cfg.svh beside it.
*/
package psf_pkg;
  // Order matches the vector slots 0 to 5
  typedef enum logic [2:0] {
    PSF_EXC_ARITH,
    PSF_EXC_IFAULT,
    PSF_EXC_INT,
    PSF_EXC_MM,
    PSF_EXC_SYS,
    PSF_EXC_UNA
  } psf_exc_e;
  typedef logic [63:0] psf_word_t;
endpackage

/* File: verif/psf_state_file_sva.sv */
/*
  Checker for the state file: event answers, mode changes, alignment.
  Assumes it is bound to psf_state_file and sees only its ports.
*/
`timescale 1ns/1ps
module psf_state_file_sva
  import psf_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      rst_i,
  input wire logic      wb_ack_o,
  input wire logic      exc_i,
  input wire logic      ret_i,
  input wire logic [3:0] ret_ps_i,
  input wire logic      sc_i,
  input wire logic      fp_issue_i,
  input wire logic      stk_access_i,
  input wire psf_word_t stk_addr_i,
  input wire logic      sc_ok_o,
  input wire logic      fp_fault_o,
  input wire logic      fp_commit_o,
  input wire logic      dispatch_o,
  input wire psf_word_t dispatch_pc_o,
  input wire logic      gp_wr_o,
  input wire logic      sp_load_o,
  input wire logic      stack_halt_o,
  input wire psf_word_t pc_o,
  input wire logic      user_mode_o,
  input wire logic [2:0] ipl_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_exc_dispatch: assert property (exc_i |=> dispatch_o)
    else $error("no dispatch after exception");
  a_user_entry: assert property (exc_i && user_mode_o && !ret_i &&
    !$past(exc_i) && !$past(ret_i) |=> gp_wr_o && sp_load_o)
    else $error("user entry missed gp or sp load");
  a_exc_kernel: assert property (exc_i && !ret_i |=> ##1 !user_mode_o)
    else $error("exception left user mode");
  a_ret_ps: assert property (ret_i && !exc_i ##1 !exc_i |=>
    {user_mode_o, ipl_o} == $past(ret_ps_i, 2))
    else $error("status word not taken from return");
  a_ret_sp: assert property (ret_i && ret_ps_i[3] && !exc_i |=> sp_load_o)
    else $error("no stack load on return");
  a_fp_gate: assert property (fp_issue_i && !exc_i |=>
    fp_fault_o != fp_commit_o)
    else $error("fp issue neither faulted nor committed");
  a_fault_quiet: assert property (fp_fault_o |-> dispatch_o && !fp_commit_o)
    else $error("fp fault committed or did not dispatch");
  a_misalign_halt: assert property (stk_access_i &&
    stk_addr_i[2:0] != 3'h0 |=> ##1 stack_halt_o)
    else $error("misaligned stack access did not halt");
  a_pc_aligned: assert property (pc_o[1:0] == 2'h0 &&
    dispatch_pc_o[1:0] == 2'h0)
    else $error("pc low bits not zero");
  a_sc_cause: assert property (sc_ok_o |-> $past(sc_i))
    else $error("sc success without sc");

  c_user_exc: cover property (exc_i && user_mode_o);
  c_fp_fault: cover property (fp_fault_o);
  c_sc_ok: cover property (sc_ok_o);
  c_halt: cover property ($rose(stack_halt_o));
endmodule // psf_state_file_sva

bind psf_state_file psf_state_file_sva i_psf_state_file_sva (.*);

/* File: verif/psf_state_file_test.sv */
/*
  Bench for the state file: register map, exception and return flows,
  FP gating, reservation, stack halt, translation root, cycle total.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module psf_state_file_test;
  import psf_pkg::*;
  localparam logic [63:0] CPUN = 64'h5; // Arbitrary processor number
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, ret_ps_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, c;
  logic        exc_i, ret_i, ll_i, sc_i, fp_issue_i, stk_access_i;
  logic        sc_ok_o, fp_fault_o, fp_commit_o, dispatch_o, gp_wr_o;
  logic        sp_load_o, stack_halt_o, perf_watch_o, user_mode_o;
  logic [2:0]  ipl_o;
  psf_exc_e    exc_kind_i;
  psf_word_t   cur_sp_i, stk_addr_i, xlat_va_i, dispatch_pc_o, gp_o, sp_o;
  psf_word_t   xlat_root_o, pc_o, v, user_sp, kern_sp;
  int          bad_count, n_checks;

  psf_state_file #(.CPU_ID(CPUN), .CPU_LIMIT(8)) i_psf_state_file (.*);

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Compare with case equality so unknowns never match
  task automatic chk(input string nm, input logic [64:0] s, e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [63:0] pat(input int k);
    return 64'h0123456789ABCDEF ^ (64'h0101010101010101 * 64'(k));
  endfunction

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic w64(input int s, input logic [63:0] d);
    wb(1'b1, 6'(2 * s), d[31:0]);
    wb(1'b1, 6'(2 * s + 1), d[63:32]);
  endtask

  task automatic r64(input int s);
    wb(1'b0, 6'(2 * s), 32'h0);
    v[31:0] = q;
    wb(1'b0, 6'(2 * s + 1), 32'h0);
    v[63:32] = q;
  endtask

  // Pulses last one cycle; answers are looked at one cycle later
  task automatic go;
    @(posedge clk_i);
    {exc_i, ret_i, ll_i, sc_i, fp_issue_i, stk_access_i} <= 6'h00;
    @(posedge clk_i);
  endtask

  task automatic ret(input logic [3:0] p, input psf_word_t sp);
    ret_i <= 1'b1;
    ret_ps_i <= p;
    cur_sp_i <= sp;
    go;
  endtask

  task automatic exc(input int k, input psf_word_t sp);
    exc_i <= 1'b1;
    exc_kind_i <= psf_exc_e'(k);
    cur_sp_i <= sp;
    go;
  endtask

  task automatic t_reset;
    wb(1'b0, 6'h24, 32'h0);
    chk("ps", q, 32'h7);
    r64(13);
    chk("bound", v, 64'hFFFFFFFFFFFFFFFF);
    wb(1'b1, 6'h28, 32'hFFFF);
    r64(20);
    chk("cpu", v, CPUN);
    wb(1'b0, 6'h3F, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask

  task automatic t_regs;
    for (int k = 0; k < 17; k++) w64(k, pat(k));
    for (int k = 0; k < 17; k++) begin
      r64(k);
      chk("slot", v, k == 9 ? pat(k) & ~64'h3 : pat(k));
    end
    wb(1'b1, 6'h25, 32'h70);
    wb(1'b0, 6'h25, 32'h0);
    chk("mcheck_err_summary", q[6:4], 3'h7);
    user_sp = pat(8);
  endtask

  // Every kind from user mode, each preceded by a return
  task automatic t_exc;
    for (int k = 0; k < 6; k++) begin
      kern_sp = 64'h8000 + 64'(k * 8);
      ret(4'h8, kern_sp);
      chk("ret_sp", {sp_load_o, sp_o}, {1'b1, user_sp});
      @(posedge clk_i);
      chk("ret_ps", {user_mode_o, ipl_o}, 4'h8);
      user_sp = 64'h4000 + 64'(k * 8);
      exc(k, user_sp);
      chk("vec", {dispatch_o, dispatch_pc_o}, {1'b1, pat(k) & ~64'h3});
      chk("gp", {gp_wr_o, gp_o}, {1'b1, pat(6)});
      chk("kern_sp", {sp_load_o, sp_o}, {1'b1, kern_sp});
      r64(8);
      chk("user_sp", v, user_sp);
      wb(1'b0, 6'h25, 32'h0);
      chk("seen", q[1], k == 2);
      chk("exc_ps", {user_mode_o, ipl_o}, 4'h0);
    end
  endtask

  task automatic t_fp;
    fp_issue_i <= 1'b1;
    go;
    chk("fp_off", {fp_fault_o, fp_commit_o}, 2'b10);
    chk("fp_vec", dispatch_pc_o, pat(1) & ~64'h3);
    @(posedge clk_i);
    chk("fp_pc", pc_o, pat(1) & ~64'h3);
    r64(8);
    chk("fp_user_sp", v, user_sp);
    wb(1'b1, 6'h26, 32'h1);
    wb(1'b1, 6'h27, 32'h40000000);
    @(posedge clk_i);
    chk("perf", perf_watch_o, 1'b1);
    fp_issue_i <= 1'b1;
    go;
    chk("fp_on", {fp_fault_o, fp_commit_o}, 2'b01);
  endtask

  // Reservation, then kernel-only value seen from user mode
  task automatic t_lock_user;
    ll_i <= 1'b1;
    go;
    sc_i <= 1'b1;
    go;
    chk("sc_set", sc_ok_o, 1'b1);
    ll_i <= 1'b1;
    go;
    ret(4'h8, kern_sp);
    sc_i <= 1'b1;
    go;
    chk("sc_clr", sc_ok_o, 1'b0);
    w64(15, 64'h1234);
    r64(15);
    chk("cpu_user", v, 64'h0);
    w64(16, 64'h5678);
    r64(16);
    chk("proc_val", v, 64'h5678);
    exc(0, user_sp);
    r64(15);
    chk("cpu_kern", v, pat(15));
  endtask

  task automatic t_misc;
    stk_addr_i <= 64'h10;
    stk_access_i <= 1'b1;
    go;
    chk("halt_ok", stack_halt_o, 1'b0);
    stk_addr_i <= 64'h14;
    stk_access_i <= 1'b1;
    go;
    @(posedge clk_i);
    chk("halt", stack_halt_o, 1'b1);
    wb(1'b1, 6'h25, 32'h4);
    @(posedge clk_i);
    chk("halt_clr", stack_halt_o, 1'b0);
    w64(12, 64'hABC);
    w64(13, 64'h80000000000);
    xlat_va_i <= 64'h7FFFFFFFFFF;
    repeat (2) @(posedge clk_i);
    chk("root_lo", xlat_root_o, pat(11));
    xlat_va_i <= 64'h80000000000;
    repeat (2) @(posedge clk_i);
    chk("root_hi", xlat_root_o, 64'hABC);
    wb(1'b1, 6'h22, 32'hFFFFFFF0);
    wb(1'b1, 6'h23, 32'h20);
    wb(1'b0, 6'h23, 32'h0);
    chk("bias", q, 32'h20);
    wb(1'b0, 6'h22, 32'h0);
    c = q;
    wb(1'b0, 6'h2A, 32'h0);
    chk("total", 32'(q - 32'h20 - c) < 32'h10, 1'b1);
    repeat (20) @(posedge clk_i);
    wb(1'b0, 6'h22, 32'h0);
    chk("wrap", q < 32'h40, 1'b1);
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, exc_i, ret_i} = 5'h00;
    {ll_i, sc_i, fp_issue_i, stk_access_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    ret_ps_i = 4'h0;
    exc_kind_i = PSF_EXC_ARITH;
    cur_sp_i = 64'h0;
    stk_addr_i = 64'h0;
    xlat_va_i = 64'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_regs;
    t_exc;
    t_fp;
    t_lock_user;
    t_misc;
    complete_run;
  end

  // Watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    complete_run;
  end
endmodule // psf_state_file_test
